// ---- hsitc_pkg.sv ----
package hsitc_pkg;

	localparam int CHANNELS = 8;
	localparam int SLOTS    = 24;
	localparam int ADDR_W   = 16;
	localparam int DATA_W   = 8;
	localparam int CHAN_W   = 3;
	localparam int SLOT_W   = 5;
	localparam int COUNT_W  = 7;
	localparam int TX_TIMESLOT_CONTROL_IDX_W = 8;

	// per-channel register offsets, channel number sits in address bits 14:12
	localparam logic [11:0] OFS_TX_SIGNALING_LINK_SELECT_REG     = 12'h10A;
	localparam logic [11:0] OFS_RX3_COUNT  = 12'h160;
	localparam logic [11:0] OFS_IRQ_STATUS = 12'h170;
	localparam logic [11:0] OFS_IRQ_MASK   = 12'h171;
	localparam logic [11:0] OFS_DEVICE_IDENTIFIER      = 12'h1FE;
	localparam logic [11:0] OFS_SILICON_REVISION      = 12'h1FF;
	localparam logic [11:0] OFS_TX_TIMESLOT_CONTROL_FIRST = 12'h300;
	localparam logic [11:0] OFS_TX_TIMESLOT_CONTROL_LAST  = 12'h317;

	// field positions
	localparam int RX3_BUF_BIT   = 7;
	localparam int TX_TIMESLOT_CONTROL_LINK_HI  = 7;
	localparam int TX_TIMESLOT_CONTROL_LINK_LO  = 6;
	localparam int TX_TIMESLOT_CONTROL_ZS_HI    = 5;
	localparam int TX_TIMESLOT_CONTROL_ZS_LO    = 4;
	localparam int TX_SIGNALING_LINK_SELECT_REG_SRC_HI = 3;
	localparam int TX_SIGNALING_LINK_SELECT_REG_SRC_LO = 2;
	localparam int IRQ_RX_EOT    = 0;
	localparam int IRQ_TX_EOT    = 1;
	localparam int IRQ_W         = 2;

	// reset values
	localparam logic [7:0] RX3_COUNT_RST = 8'h00;
	localparam logic [7:0] TX_TIMESLOT_CONTROL_RST      = 8'h80;
	localparam logic [7:0] TX_SIGNALING_LINK_SELECT_REG_RST    = 8'h00;
	localparam logic [1:0] IRQ_MASK_RST  = 2'h0;

	// link controller select codes
	localparam logic [1:0] LINK_CTL1     = 2'h0;
	localparam logic [1:0] LINK_CTL2     = 2'h1;
	localparam logic [1:0] LINK_EXTERNAL = 2'h2;
	localparam logic [1:0] LINK_CTL3     = 2'h3;

	// zero suppression codes and patterns (telecom bit 1 is the msb)
	localparam logic [1:0] ZS_NONE        = 2'h0;
	localparam logic [1:0] ZS_BIT7        = 2'h1;
	localparam logic [1:0] ZS_ALT         = 2'h2;
	localparam logic [1:0] ZS_DATA        = 2'h3;
	localparam logic [7:0] ZS_BIT7_MASK   = 8'h02;
	localparam logic [7:0] ZS_BIT8_MASK   = 8'h01;
	localparam logic [7:0] ZS_DATA_OCTET  = 8'h98;

	typedef enum logic [1:0] {
		SRC_CTL1,
		SRC_CTL2,
		SRC_CTL3,
		SRC_EXTERNAL
	} hsitc_src_e;

	typedef struct packed {
		logic                mos_done;
		logic                bos_rep;
		logic [CHAN_W-1:0]   chan;
		logic                buf_sel;
		logic [COUNT_W-1:0]  length;
	} hsitc_rx_evt_s;

	typedef struct packed {
		logic                bos_rep;
		logic [CHAN_W-1:0]   chan;
	} hsitc_tx_evt_s;

	typedef struct packed {
		logic                valid;
		logic [CHAN_W-1:0]   chan;
		logic [SLOT_W-1:0]   slot;
		logic [7:0]          octet;
		logic                sig_frame;
		logic                sig_bit;
	} hsitc_slot_in_s;

	typedef struct packed {
		logic                valid;
		logic [CHAN_W-1:0]   chan;
		logic [SLOT_W-1:0]   slot;
		logic [7:0]          octet;
		hsitc_src_e          src;
		logic [1:0]          ext_src;
		logic                datalink_ok;
	} hsitc_slot_out_s;

	function automatic logic hsitc_chan_ok(input logic [ADDR_W-1:0] addr);
		return (addr[15] == 1'b0);
	endfunction

	function automatic logic [TX_TIMESLOT_CONTROL_IDX_W-1:0] hsitc_tx_timeslot_control_idx(input logic [CHAN_W-1:0] chan,
		input logic [SLOT_W-1:0] slot);
		logic [TX_TIMESLOT_CONTROL_IDX_W-1:0] base;
		base = TX_TIMESLOT_CONTROL_IDX_W'(chan) * TX_TIMESLOT_CONTROL_IDX_W'(SLOTS);
		return base + TX_TIMESLOT_CONTROL_IDX_W'(slot);
	endfunction

endpackage

// ---- hsitc_regs.sv ----
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
module hsitc_regs #(
	parameter logic [7:0] DEVICE_ID = 8'hA5,  // arbitrary value
	parameter logic [7:0] REVISION  = 8'h01   // arbitrary value
) (
	input  wire logic                                       clock_i,            // 200 MHz clock
	input  wire logic                                       reset_i,            // async reset, active high
	input  wire logic [hsitc_pkg::ADDR_W-1:0]               addr_i,             // register address
	input  wire logic [hsitc_pkg::DATA_W-1:0]               wr_data_i,          // write data
	input  wire logic                                       wr_i,               // write strobe
	input  wire logic                                       rd_i,               // read strobe
	output logic      [hsitc_pkg::DATA_W-1:0]               rd_data_o,          // read data, next cycle
	input  hsitc_pkg::hsitc_rx_evt_s                        rx3_evt_i,          // receive controller 3 events
	input  wire logic [hsitc_pkg::CHANNELS-1:0]             rx3_bit_oriented_i, // receive bit-oriented mode
	input  hsitc_pkg::hsitc_tx_evt_s                        tx3_evt_i,          // transmit controller 3 events
	input  wire logic [hsitc_pkg::CHANNELS-1:0]             tx3_bit_oriented_i, // transmit bit-oriented mode
	input  wire logic [hsitc_pkg::CHANNELS-1:0][hsitc_pkg::COUNT_W-1:0] tx3_rep_limit_i, // transmit repetitions
	output logic      [hsitc_pkg::CHANNELS-1:0]             tx3_halt_o,         // transmit controller 3 halted
	input  hsitc_pkg::hsitc_slot_in_s                       slot_i,             // outgoing timeslot octet
	output hsitc_pkg::hsitc_slot_out_s                      slot_o,             // processed octet, registered
	output logic                                            irq_o               // level interrupt
);
	import hsitc_pkg::*;

	logic [7:0]       tx_signaling_link_select_reg_r     [CHANNELS];
	logic [7:0]       rx3_r        [CHANNELS];
	logic [IRQ_W-1:0] irq_status_r [CHANNELS];
	logic [IRQ_W-1:0] irq_mask_r   [CHANNELS];
	logic [7:0]       tx_timeslot_control_r       [CHANNELS*SLOTS];
	logic [7:0]       rd_data_r;
	logic             irq_r;
	hsitc_slot_out_s  slot_r;

	// address decode
	wire              chan_ok  = hsitc_chan_ok(addr_i);
	wire [CHAN_W-1:0] chan     = addr_i[14:12];
	wire [11:0]       ofs      = addr_i[11:0];
	wire [11:0]       tx_timeslot_control_ofs = ofs - OFS_TX_TIMESLOT_CONTROL_FIRST;
	wire              hit_tx_timeslot_control = chan_ok && (ofs >= OFS_TX_TIMESLOT_CONTROL_FIRST) && (ofs <= OFS_TX_TIMESLOT_CONTROL_LAST);
	wire              hit_tsd  = chan_ok && (ofs == OFS_TX_SIGNALING_LINK_SELECT_REG);
	wire              hit_rx3  = chan_ok && (ofs == OFS_RX3_COUNT);
	wire              hit_ist  = chan_ok && (ofs == OFS_IRQ_STATUS);
	wire              hit_imk  = chan_ok && (ofs == OFS_IRQ_MASK);
	wire              hit_dev  = chan_ok && (ofs == OFS_DEVICE_IDENTIFIER);
	wire              hit_rev  = chan_ok && (ofs == OFS_SILICON_REVISION);
	wire [TX_TIMESLOT_CONTROL_IDX_W-1:0] bus_idx = hsitc_tx_timeslot_control_idx(chan, tx_timeslot_control_ofs[SLOT_W-1:0]);

	wire [7:0] rd_mux = hit_tx_timeslot_control ? tx_timeslot_control_r[bus_idx] :
	                    hit_tsd  ? tx_signaling_link_select_reg_r[chan] :
	                    hit_rx3  ? rx3_r[chan] :
	                    hit_ist  ? {{(8-IRQ_W){1'b0}}, irq_status_r[chan]} :
	                    hit_imk  ? {{(8-IRQ_W){1'b0}}, irq_mask_r[chan]} :
	                    hit_dev  ? DEVICE_ID :
	                    hit_rev  ? REVISION :
	                    8'h00;

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i)
			rd_data_r <= 8'h00;
		else
			rd_data_r <= rd_i ? rd_mux : 8'h00;
	end

	// timeslot control array, lower nibble is stored but unused here
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			for (int i = 0; i < CHANNELS*SLOTS; i++)
				tx_timeslot_control_r[i] <= TX_TIMESLOT_CONTROL_RST;
		end else if (wr_i && hit_tx_timeslot_control) begin
			tx_timeslot_control_r[bus_idx] <= wr_data_i;
		end
	end

	wire [CHANNELS-1:0] rx_eot;
	wire [CHANNELS-1:0] tx_eot;

	for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
		wire sel_wr   = wr_i && (chan == CHAN_W'(c));
		wire rx_here  = (rx3_evt_i.chan == CHAN_W'(c));
		wire rx_mos   = rx3_evt_i.mos_done && rx_here && !rx3_bit_oriented_i[c];
		wire rx_rep   = rx3_evt_i.bos_rep && rx_here && rx3_bit_oriented_i[c];
		wire tx_rep   = tx3_evt_i.bos_rep && (tx3_evt_i.chan == CHAN_W'(c)) && tx3_bit_oriented_i[c];
		wire rx_bos_eot;
		wire [IRQ_W-1:0] irq_set;
		wire [IRQ_W-1:0] irq_clr;

		// a software write to the count restarts the repetition tally
		hsitc_rep_counter #(
			.CNT_W     (COUNT_W)
		) u_rx_rep (
			.clock_i   (clock_i),
			.reset_i   (reset_i),
			.clear_i   (!rx3_bit_oriented_i[c] || (sel_wr && hit_rx3)),
			.rep_i     (rx_rep),
			.limit_i   (rx3_r[c][COUNT_W-1:0]),
			.done_o    (rx_bos_eot),
			.reached_o ()
		);

		hsitc_rep_counter #(
			.CNT_W     (COUNT_W)
		) u_tx_rep (
			.clock_i   (clock_i),
			.reset_i   (reset_i),
			.clear_i   (!tx3_bit_oriented_i[c]),
			.rep_i     (tx_rep),
			.limit_i   (tx3_rep_limit_i[c]),
			.done_o    (tx_eot[c]),
			.reached_o (tx3_halt_o[c])
		);

		assign rx_eot[c] = rx_bos_eot || rx_mos;
		assign irq_set   = {tx_eot[c], rx_eot[c]};
		assign irq_clr   = (sel_wr && hit_ist) ? wr_data_i[IRQ_W-1:0] : '0;

		// hardware update beats a software write in the same cycle
		always_ff @(posedge clock_i or posedge reset_i) begin
			if (reset_i)
				rx3_r[c] <= RX3_COUNT_RST;
			else if (rx_mos)
				rx3_r[c] <= {rx3_evt_i.buf_sel, rx3_evt_i.length};
			else if (sel_wr && hit_rx3)
				rx3_r[c] <= wr_data_i;
		end

		always_ff @(posedge clock_i or posedge reset_i) begin
			if (reset_i) begin
				tx_signaling_link_select_reg_r[c]     <= TX_SIGNALING_LINK_SELECT_REG_RST;
				irq_mask_r[c]   <= IRQ_MASK_RST;
				irq_status_r[c] <= '0;
			end else begin
				if (sel_wr && hit_tsd)
					tx_signaling_link_select_reg_r[c] <= wr_data_i;
				if (sel_wr && hit_imk)
					irq_mask_r[c] <= wr_data_i[IRQ_W-1:0];
				irq_status_r[c] <= (irq_status_r[c] & ~irq_clr) | irq_set;
			end
		end
	end

	wire [CHANNELS-1:0] irq_any;
	for (genvar c = 0; c < CHANNELS; c++) begin : g_irq
		assign irq_any[c] = |(irq_status_r[c] & irq_mask_r[c]);
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i)
			irq_r <= 1'b0;
		else
			irq_r <= |irq_any;
	end

	// outgoing timeslot path, one register stage
	wire [TX_TIMESLOT_CONTROL_IDX_W-1:0] slot_idx = hsitc_tx_timeslot_control_idx(slot_i.chan, slot_i.slot);
	hsitc_slot_out_s      slot_nxt;

	hsitc_slot_proc u_slot (
		.slot_i   (slot_i),
		.ctl_i    (tx_timeslot_control_r[slot_idx]),
		.tx_signaling_link_select_reg_i (tx_signaling_link_select_reg_r[slot_i.chan]),
		.slot_o   (slot_nxt)
	);

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i)
			slot_r <= '0;
		else
			slot_r <= slot_nxt;
	end

	assign rd_data_o = rd_data_r;
	assign irq_o     = irq_r;
	assign slot_o    = slot_r;
endmodule

// ---- hsitc_regs_properties.sv ----
`timescale 1ns/1ps
module hsitc_regs_properties #(
	parameter logic [7:0] DEVICE_ID = 8'hA5, // arbitrary value
	parameter logic [7:0] REVISION  = 8'h01  // arbitrary value
) (
	input  wire logic                          clock_i,            // clock
	input  wire logic                          reset_i,            // async reset
	input  wire logic [15:0]                   addr_i,             // address
	input  wire logic [7:0]                    wr_data_i,          // write data
	input  wire logic                          wr_i,               // write strobe
	input  wire logic                          rd_i,               // read strobe
	input  wire logic [7:0]                    rd_data_o,          // read data
	input  hsitc_pkg::hsitc_rx_evt_s           rx3_evt_i,          // rx events
	input  wire logic [7:0]                    rx3_bit_oriented_i, // rx mode
	input  hsitc_pkg::hsitc_tx_evt_s           tx3_evt_i,          // tx events
	input  wire logic [7:0]                    tx3_bit_oriented_i, // tx mode
	input  wire logic [7:0][6:0]               tx3_rep_limit_i,    // tx limits
	input  wire logic [7:0]                    tx3_halt_o,         // tx halted
	input  hsitc_pkg::hsitc_slot_in_s          slot_i,             // octet in
	input  hsitc_pkg::hsitc_slot_out_s         slot_o,             // octet out
	input  wire logic                          irq_o               // interrupt
);
	import hsitc_pkg::*;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);
	wire rd_ok = rd_i && !wr_i && !addr_i[15];

	a_rd_idle_zero: assert property (!rd_i |=> rd_data_o == 8'h00)
		else $error("read data not zero outside read cycle");
	a_device_identifier_fixed: assert property (rd_ok && addr_i[11:0] == OFS_DEVICE_IDENTIFIER |=> rd_data_o == DEVICE_ID)
		else $error("identification byte wrong");
	a_silicon_revision_fixed: assert property (rd_ok && addr_i[11:0] == OFS_SILICON_REVISION |=> rd_data_o == REVISION)
		else $error("revision byte wrong");
	a_bad_chan_zero: assert property (rd_i && addr_i[15] |=> rd_data_o == 8'h00)
		else $error("out of range channel read not zero");
	a_slot_latency: assert property (slot_i.valid |=> slot_o.valid && slot_o.slot == $past(slot_i.slot)
		&& slot_o.chan == $past(slot_i.chan))
		else $error("timeslot octet not forwarded after one cycle");
	a_ext_src_idle: assert property (slot_o.valid && slot_o.src != SRC_EXTERNAL |-> slot_o.ext_src == 2'h0)
		else $error("external source set for internal controller");
	a_datalink_ctl1: assert property (slot_o.valid && slot_o.datalink_ok |-> slot_o.src == SRC_CTL1)
		else $error("data link on controller other than first");
	a_halt_needs_mode: assert property ((tx3_halt_o & ~$past(tx3_bit_oriented_i)) == 8'h00)
		else $error("transmit halt without bit-oriented mode");

	c_device_identifier_read: cover property (rd_ok && addr_i[11:0] == OFS_DEVICE_IDENTIFIER);
	c_irq_rise: cover property ($rose(irq_o));
	c_halt_rise: cover property ($rose(tx3_halt_o[2]));
endmodule

bind hsitc_regs hsitc_regs_properties #(.DEVICE_ID(DEVICE_ID), .REVISION(REVISION)) u_props (
	.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
	.rd_i(rd_i), .rd_data_o(rd_data_o), .rx3_evt_i(rx3_evt_i), .rx3_bit_oriented_i(rx3_bit_oriented_i),
	.tx3_evt_i(tx3_evt_i), .tx3_bit_oriented_i(tx3_bit_oriented_i), .tx3_rep_limit_i(tx3_rep_limit_i),
	.tx3_halt_o(tx3_halt_o), .slot_i(slot_i), .slot_o(slot_o), .irq_o(irq_o));

// ---- hsitc_regs_tb.sv ----
`timescale 1ns/1ps
module hsitc_regs_tb;
	import hsitc_pkg::*;
	localparam logic [7:0] ID  = 8'h5C; // arbitrary value
	localparam logic [7:0] REV = 8'h03; // arbitrary value
	logic            clock_i, reset_i, wr_i, rd_i, irq_o;
	logic [15:0]     addr_i;
	logic [7:0]      wr_data_i, rd_data_o, rx3_bit_oriented_i, tx3_bit_oriented_i, tx3_halt_o, oe;
	logic [7:0][6:0] tx3_rep_limit_i;
	hsitc_rx_evt_s   rx3_evt_i;
	hsitc_tx_evt_s   tx3_evt_i;
	hsitc_slot_in_s  slot_i;
	hsitc_slot_out_s slot_o;
	int              err_count, cmp_count, cyc;

	hsitc_regs #(.DEVICE_ID(ID), .REVISION(REV)) DUT (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i),
		.wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .rx3_evt_i(rx3_evt_i),
		.rx3_bit_oriented_i(rx3_bit_oriented_i), .tx3_evt_i(tx3_evt_i), .tx3_bit_oriented_i(tx3_bit_oriented_i),
		.tx3_rep_limit_i(tx3_rep_limit_i), .tx3_halt_o(tx3_halt_o), .slot_i(slot_i), .slot_o(slot_o), .irq_o(irq_o));

	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	function automatic logic [15:0] ad(input logic [2:0] ch, input logic [11:0] ofs);
		return {1'b0, ch, ofs};
	endfunction

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wr_data_i <= d;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask

	task rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clock_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 chk(rd_data_o, e);
	endtask

	// one pulse, then a settle gap long enough for status and irq
	task rx_ev(input logic message_oriented_mode, input logic [7:0] bl);
		@(posedge clock_i);
		rx3_evt_i <= hsitc_rx_evt_s'({message_oriented_mode, ~message_oriented_mode, 3'h0, bl});
		@(posedge clock_i);
		rx3_evt_i <= '0;
		repeat (3) @(posedge clock_i);
	endtask

	task slot(input logic [7:0] ctl, input logic sf, input logic sb, input logic [7:0] eo);
		hsitc_src_e smap [4];
		smap = '{SRC_CTL1, SRC_CTL2, SRC_EXTERNAL, SRC_CTL3};
		wr(ad(3'h1, OFS_TX_TIMESLOT_CONTROL_FIRST + 12'h005), ctl);
		@(posedge clock_i);
		slot_i <= '{valid: 1'b1, chan: 3'h1, slot: 5'h05, octet: 8'h40, sig_frame: sf, sig_bit: sb};
		@(posedge clock_i);
		slot_i.valid <= 1'b0;
		#1 chk(slot_o.octet, eo);
		chk(slot_o.src, smap[ctl[7:6]]);
		chk(slot_o.ext_src, (ctl[7:6] == 2'h2) ? 2'h2 : 2'h0);
		chk(slot_o.datalink_ok, ctl[7:6] == 2'h0);
	endtask

	task test_done;
		$display("errors=%0d compares=%0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// whole run needs a little over a hundred cycles
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			test_done;
		end
	end

	initial begin
		reset_i = 1'b1;
		wr_i               = 1'b0;
		rd_i               = 1'b0;
		addr_i             = 16'h0000;
		wr_data_i          = 8'h00;
		rx3_bit_oriented_i = 8'h00;
		tx3_bit_oriented_i = 8'h00;
		rx3_evt_i          = '0;
		tx3_evt_i          = '0;
		tx3_rep_limit_i    = '0;
		slot_i             = '0;
		repeat (2) @(posedge clock_i);
		reset_i <= 1'b0;
		rd(ad(3'h0, OFS_RX3_COUNT), 8'h00);
		rd(ad(3'h7, OFS_TX_TIMESLOT_CONTROL_LAST), 8'h80);
		wr(ad(3'h0, OFS_DEVICE_IDENTIFIER), 8'h00);
		rd(ad(3'h0, OFS_DEVICE_IDENTIFIER), ID);
		rd(ad(3'h4, OFS_SILICON_REVISION), REV);
		rd(16'h8160, 8'h00);
		rd(ad(3'h0, 12'h200), 8'h00);
		wr(ad(3'h3, OFS_TX_TIMESLOT_CONTROL_LAST), 8'hC0);
		rd(ad(3'h3, OFS_TX_TIMESLOT_CONTROL_LAST), 8'hC0);
		rd(ad(3'h2, OFS_TX_TIMESLOT_CONTROL_LAST), 8'h80);
		wr(ad(3'h1, OFS_TX_SIGNALING_LINK_SELECT_REG), 8'h08);
		for (int i = 0; i < 4; i++) begin
			oe = (i == 0) ? 8'h40 : (i == 1) ? 8'h42 : (i == 2) ? 8'h41 : 8'h98;
			slot({i[1:0], i[1:0], 4'h0}, 1'b0, 1'b0, oe);
		end
		slot(8'h20, 1'b1, 1'b0, 8'h42);
		slot(8'h20, 1'b1, 1'b1, 8'h40);
		wr(ad(3'h0, OFS_IRQ_MASK), 8'h03);
		rx_ev(1'b1, 8'hAA);
		chk(irq_o, 1'b1);
		rd(ad(3'h0, OFS_RX3_COUNT), 8'hAA);
		rd(ad(3'h0, OFS_IRQ_STATUS), 8'h01);
		wr(ad(3'h0, OFS_IRQ_STATUS), 8'h01);
		repeat (2) @(posedge clock_i);
		#1 chk(irq_o, 1'b0);
		wr(ad(3'h0, OFS_IRQ_MASK), 8'h00);
		rx_ev(1'b1, 8'h05);
		chk(irq_o, 1'b0);
		rd(ad(3'h0, OFS_RX3_COUNT), 8'h05);
		rd(ad(3'h0, OFS_IRQ_STATUS), 8'h01);
		wr(ad(3'h0, OFS_IRQ_STATUS), 8'h01);
		rx3_bit_oriented_i <= 8'h01;
		wr(ad(3'h0, OFS_RX3_COUNT), 8'h02);
		rx_ev(1'b0, 8'h00);
		rd(ad(3'h0, OFS_IRQ_STATUS), 8'h00);
		rx_ev(1'b0, 8'h00);
		rd(ad(3'h0, OFS_IRQ_STATUS), 8'h01);
		wr(ad(3'h0, OFS_IRQ_STATUS), 8'h01);
		wr(ad(3'h0, OFS_RX3_COUNT), 8'h00);
		repeat (3) rx_ev(1'b0, 8'h00);
		rd(ad(3'h0, OFS_IRQ_STATUS), 8'h00);
		tx3_rep_limit_i[2] <= 7'h03;
		tx3_bit_oriented_i <= 8'h04;
		repeat (3) begin
			@(posedge clock_i);
			tx3_evt_i <= '{bos_rep: 1'b1, chan: 3'h2};
		end
		@(posedge clock_i);
		tx3_evt_i <= '0;
		repeat (3) @(posedge clock_i);
		#1 chk(tx3_halt_o, 8'h04);
		rd(ad(3'h2, OFS_IRQ_STATUS), 8'h02);
		tx3_bit_oriented_i <= 8'h00;
		repeat (2) @(posedge clock_i);
		#1 chk(tx3_halt_o, 8'h00);
		test_done;
	end
endmodule

// ---- hsitc_rep_counter.sv ----
`timescale 1ns/1ps
module hsitc_rep_counter #(
	parameter int CNT_W = 7
) (
	input  wire logic             clock_i,   // system clock
	input  wire logic             reset_i,   // async reset, active high
	input  wire logic             clear_i,   // restart the count
	input  wire logic             rep_i,     // one repetition seen
	input  wire logic [CNT_W-1:0] limit_i,   // repetitions wanted, zero is endless
	output logic                  done_o,    // pulse when limit reached
	output logic                  reached_o  // level until cleared
);
	logic [CNT_W-1:0] cnt_r;
	logic             reached_r;
	logic             done_r;

	wire [CNT_W-1:0] cnt_inc   = cnt_r + 1'b1;
	wire             counting  = rep_i && (limit_i != '0) && !reached_r;
	wire             hit       = counting && (cnt_inc == limit_i);

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_r     <= '0;
			reached_r <= 1'b0;
			done_r    <= 1'b0;
		end else if (clear_i) begin
			cnt_r     <= '0;
			reached_r <= 1'b0;
			done_r    <= 1'b0;
		end else begin
			done_r <= hit;
			if (counting)
				cnt_r <= cnt_inc;
			if (hit)
				reached_r <= 1'b1;
		end
	end

	assign done_o    = done_r;
	assign reached_o = reached_r;
endmodule

// ---- hsitc_slot_proc.sv ----
`timescale 1ns/1ps
module hsitc_slot_proc (
	input  hsitc_pkg::hsitc_slot_in_s  slot_i,    // timeslot octet in
	input  wire logic [7:0]            ctl_i,     // timeslot control byte
	input  wire logic [7:0]            tx_signaling_link_select_reg_i,  // signaling/link select byte
	output hsitc_pkg::hsitc_slot_out_s slot_o     // processed octet, unregistered
);
	import hsitc_pkg::*;

	wire [1:0] link_sel = ctl_i[TX_TIMESLOT_CONTROL_LINK_HI:TX_TIMESLOT_CONTROL_LINK_LO];
	wire [1:0] zs_sel   = ctl_i[TX_TIMESLOT_CONTROL_ZS_HI:TX_TIMESLOT_CONTROL_ZS_LO];
	wire [7:0] oct      = slot_i.octet;

	// alternative scheme: bit 8 outside signaling frames, bit 7 only on a zero signaling bit
	wire [7:0] oct_alt  = slot_i.sig_frame ? (slot_i.sig_bit ? oct : (oct | ZS_BIT7_MASK))
	                                       : (oct | ZS_BIT8_MASK);
	wire [7:0] oct_out  = (zs_sel == ZS_BIT7) ? (oct | ZS_BIT7_MASK) :
	                      (zs_sel == ZS_ALT)  ? oct_alt :
	                      (zs_sel == ZS_DATA) ? ZS_DATA_OCTET :
	                      oct;

	wire hsitc_src_e src = (link_sel == LINK_CTL1)     ? SRC_CTL1 :
	                       (link_sel == LINK_CTL2)     ? SRC_CTL2 :
	                       (link_sel == LINK_EXTERNAL) ? SRC_EXTERNAL : SRC_CTL3;

	// external source code is only meaningful when src says external
	wire [1:0] ext_src  = (link_sel == LINK_EXTERNAL) ? tx_signaling_link_select_reg_i[TX_SIGNALING_LINK_SELECT_REG_SRC_HI:TX_SIGNALING_LINK_SELECT_REG_SRC_LO]
	                                                  : 2'h0;

	assign slot_o = '{
		valid:       slot_i.valid,
		chan:        slot_i.chan,
		slot:        slot_i.slot,
		octet:       oct_out,
		src:         src,
		ext_src:     ext_src,
		datalink_ok: (link_sel == LINK_CTL1)
	};
endmodule
